// File: pkg/sxteu_pkg.sv
/*
  Constants for the nibble-swap / exclusive-OR / direction-load execution unit.
  Assumes a 14-bit instruction word and a 7-bit file register space.
*/
// How it works
// - Nibble swap of file register, destination selectable.
// - Literal XOR into working register, zero flag.
// - Register XOR, destination bit picks target.
// - Direction load copies working register, no flags.
// - Four phases: decode, read, process, write.
package sxteu_pkg;
  // ************************************************************
  // Opcode fields
  // ************************************************************
  localparam int          OP_W        = 14;
  localparam int          DATA_W      = 8;
  localparam int          FADDR_W     = 7;
  localparam int          DEST_BIT    = 7;
  localparam int          DIR_SEL_W   = 3;
  localparam logic [5:0]  SWAP_HI     = 6'h0E;
  localparam logic [5:0]  REGXOR_HI   = 6'h06;
  localparam logic [5:0]  LITXOR_HI   = 6'h3A;
  localparam logic [10:0] DIRLD_HI    = 11'h00C;
  localparam logic [2:0]  DIR_SEL_MIN = 3'h5;
  localparam logic [2:0]  DIR_SEL_MAX = 3'h7;
  localparam logic [7:0]  W_RESET     = 8'h00;
  localparam logic [7:0]  DIR_RESET   = 8'hFF;
  localparam int          DIR_NUM     = 3;

  typedef enum logic [2:0] {SXT_NONE, SXT_SWAP, SXT_XORL, SXT_XORF, SXT_DIRLD} sxteu_op_t;
  typedef enum {SXT_Q1, SXT_Q2, SXT_Q3, SXT_Q4} sxteu_phase_t;
endpackage : sxteu_pkg

// File: rtl/sxteu_decode.sv
/*
  Opcode classifier for the execution unit.
  Assumes the opcode is stable for the whole instruction cycle.
*/
`timescale 1ns/10ps
module sxteu_decode
  import sxteu_pkg::*;
(
  input  wire logic [OP_W-1:0] opcode,
  output sxteu_op_t             op_kind
);
  always_comb begin
    op_kind = SXT_NONE;
    if (opcode[13:8] == SWAP_HI) begin
      op_kind = SXT_SWAP;
    end else if (opcode[13:8] == LITXOR_HI) begin
      op_kind = SXT_XORL;
    end else if (opcode[13:8] == REGXOR_HI) begin
      op_kind = SXT_XORF;
    end else if (opcode[13:3] == DIRLD_HI && opcode[2:0] >= DIR_SEL_MIN) begin
      op_kind = SXT_DIRLD;
    end
  end
endmodule : sxteu_decode

// File: rtl/sxteu_exec.sv
/*
  Execution unit for nibble swap, exclusive OR and legacy direction load.
  Assumes the core presents the opcode at the start of each four-clock
  instruction cycle (instr_start) and answers file reads combinationally.
*/
`timescale 1ns/10ps
module sxteu_exec
  import sxteu_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                instr_start,
  input  wire logic [OP_W-1:0]     opcode,
  output logic      [FADDR_W-1:0]  file_addr,
  input  wire logic [DATA_W-1:0]   file_rdata,
  output logic                     file_we,
  output logic      [DATA_W-1:0]   file_wdata,
  input  wire logic                dir_file_we,
  input  wire logic [1:0]          dir_file_sel,
  input  wire logic [DATA_W-1:0]   dir_file_wdata,
  output logic      [DATA_W-1:0]   dir_file_rdata,
  output logic      [DATA_W-1:0]   dir_port_a,
  output logic      [DATA_W-1:0]   dir_port_b,
  output logic      [DATA_W-1:0]   dir_port_c,
  output logic      [DATA_W-1:0]   w_reg,
  output logic                     zero_flag,
  output logic                     zero_we,
  output logic                     instr_done
);
  // ************************************************************
  // State
  // ************************************************************
  sxteu_phase_t             phase_q;
  sxteu_op_t                op_q, op_kind;
  logic [OP_W-1:0]          opc_q;
  logic [DATA_W-1:0]        opnd_q, res_q, w_q;
  logic [DATA_W-1:0]        dir_q [DIR_NUM];
  logic                     busy_q, zero_q, zwe_q, fwe_q, done_q;
  logic [DATA_W-1:0]        fwd_q;

  function automatic logic [DATA_W-1:0] nib_swap(input logic [DATA_W-1:0] v);
    return {v[3:0], v[7:4]};
  endfunction : nib_swap

  sxteu_decode u_dec (
    .opcode  (opcode),
    .op_kind (op_kind)
  );

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_q <= SXT_Q1;
      busy_q  <= 1'b0;
      op_q    <= SXT_NONE;
      opc_q   <= 14'h0000;
    end else begin
      case (phase_q)
        SXT_Q1: begin
          if (instr_start) begin
            op_q    <= op_kind;                           // decode
            opc_q   <= opcode;
            busy_q  <= 1'b1;
            phase_q <= SXT_Q2;
          end
        end
        SXT_Q2:  phase_q <= SXT_Q3;
        SXT_Q3:  phase_q <= SXT_Q4;
        SXT_Q4: begin
          phase_q <= SXT_Q1;
          busy_q  <= 1'b0;
        end
        default: phase_q <= SXT_Q1;
      endcase
    end
  end

  // ************************************************************
  // Read and process
  // ************************************************************
  assign file_addr = opc_q[FADDR_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opnd_q <= 8'h00;
    end else if (busy_q && phase_q == SXT_Q2) begin
      opnd_q <= file_rdata;                               // read
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      res_q <= 8'h00;
    end else if (busy_q && phase_q == SXT_Q3) begin
      case (op_q)                                         // process
        SXT_SWAP:  res_q <= nib_swap(opnd_q);
        SXT_XORL:  res_q <= w_q ^ opc_q[DATA_W-1:0];
        SXT_XORF:  res_q <= w_q ^ opnd_q;
        SXT_DIRLD: res_q <= w_q;
        default:   res_q <= w_q;
      endcase
    end
  end

  // ************************************************************
  // Write back
  // ************************************************************
  // Destination bit only matters for file-register forms
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      w_q <= W_RESET;
    end else if (busy_q && phase_q == SXT_Q4) begin
      if (op_q == SXT_XORL) begin
        w_q <= res_q;
      end else if ((op_q == SXT_SWAP || op_q == SXT_XORF) && !opc_q[DEST_BIT]) begin
        w_q <= res_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fwe_q <= 1'b0;
      fwd_q <= 8'h00;
    end else begin
      fwe_q <= busy_q && phase_q == SXT_Q4 && opc_q[DEST_BIT]
               && (op_q == SXT_SWAP || op_q == SXT_XORF);
      fwd_q <= res_q;
    end
  end

  // Zero flag only for XOR; carry and digit carry are never touched here
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      zero_q <= 1'b0;
      zwe_q  <= 1'b0;
    end else begin
      zwe_q <= busy_q && phase_q == SXT_Q4 && (op_q == SXT_XORL || op_q == SXT_XORF);
      if (busy_q && phase_q == SXT_Q4 && (op_q == SXT_XORL || op_q == SXT_XORF)) begin
        zero_q <= (res_q == 8'h00);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && phase_q == SXT_Q4;
    end
  end

  // ************************************************************
  // Direction registers
  // ************************************************************
  // A same-cycle file write loses to a direction load, which owns Q4
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < DIR_NUM; i++) begin
        dir_q[i] <= DIR_RESET;
      end
    end else if (busy_q && phase_q == SXT_Q4 && op_q == SXT_DIRLD) begin
      dir_q[2'(opc_q[DIR_SEL_W-1:0] - DIR_SEL_MIN)] <= res_q;
    end else if (dir_file_we && dir_file_sel < 2'(DIR_NUM)) begin
      dir_q[dir_file_sel] <= dir_file_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_file_rdata <= 8'h00;
    end else begin
      dir_file_rdata <= (dir_file_sel < 2'(DIR_NUM)) ? dir_q[dir_file_sel] : 8'h00;
    end
  end

  assign dir_port_a = dir_q[0];
  assign dir_port_b = dir_q[1];
  assign dir_port_c = dir_q[2];
  assign w_reg      = w_q;
  assign zero_flag  = zero_q;
  assign zero_we    = zwe_q;
  assign file_we    = fwe_q;
  assign file_wdata = fwd_q;
  assign instr_done = done_q;
endmodule : sxteu_exec

// File: test/sxteu_exec_assertions.sv
/* Port checker for sxteu_exec.
   Assumes it is bound to the exec unit and sees its ports only. */
`timescale 1ns/10ps
module sxteu_exec_chk
  import sxteu_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              instr_start,
  input wire logic              instr_done,
  input wire logic              zero_we,
  input wire logic              zero_flag,
  input wire logic              file_we,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [DATA_W-1:0] w_reg,
  input wire logic [DATA_W-1:0] dir_port_a,
  input wire logic              dir_file_we
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_done_pulse;
    instr_done ##1 !instr_done;
  endsequence
  property p_done_spacing;  instr_done |-> $past(instr_start, 4); endproperty
  property p_done_pulse;    instr_done |-> s_done_pulse; endproperty
  property p_zero_we_done;  zero_we |-> instr_done; endproperty
  property p_file_we_done;  file_we |-> instr_done; endproperty
  // Zero reflects whichever destination got the result
  property p_zero_value;
    zero_we |-> zero_flag == ((file_we ? file_wdata : w_reg) == 8'h00);
  endproperty
  property p_w_kept;        file_we |-> $stable(w_reg); endproperty
  property p_w_when;        $changed(w_reg) |-> instr_done; endproperty
  property p_dir_when;      $changed(dir_port_a) |-> instr_done || $past(dir_file_we); endproperty
  a_done_spacing: assert property (p_done_spacing) else $error("done not 4 edges after start");
  a_done_pulse:   assert property (p_done_pulse) else $error("done longer than one cycle");
  a_zero_we_done: assert property (p_zero_we_done) else $error("zero strobe outside done");
  a_file_we_done: assert property (p_file_we_done) else $error("file write outside done");
  a_zero_value:   assert property (p_zero_value) else $error("zero flag wrong");
  a_w_kept:       assert property (p_w_kept) else $error("w changed on file write");
  a_w_when:       assert property (p_w_when) else $error("w changed outside write phase");
  a_dir_when:     assert property (p_dir_when) else $error("direction changed unasked");
endmodule : sxteu_exec_chk

bind sxteu_exec sxteu_exec_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .instr_start(instr_start),
  .instr_done(instr_done), .zero_we(zero_we), .zero_flag(zero_flag), .file_we(file_we),
  .file_wdata(file_wdata), .w_reg(w_reg), .dir_port_a(dir_port_a), .dir_file_we(dir_file_we));

// File: test/sxteu_exec_tb_top.sv
/* Self-checking bench for sxteu_exec.
   Assumes the checker file is compiled alongside and binds itself. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sxteu_exec_tb_top;
  import sxteu_pkg::*;
  // ************************************************************
  // Stimulus and scenarios
  // ************************************************************
  logic clk_sys = 0, rst_n = 0, instr_start = 0, dir_file_we = 0;
  logic [13:0] opcode = '0;
  logic [7:0]  file_rdata = '0, dir_file_wdata = '0, w_reg, dir_a, dir_b, dir_c, fwd, drd;
  logic [1:0]  dir_file_sel = '0;
  logic [6:0]  faddr;
  logic        fwe, zf, zwe, instr_done;
  int          n_errors = 0, total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  sxteu_exec dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_start(instr_start), .opcode(opcode),
    .file_addr(faddr), .file_rdata(file_rdata), .file_we(fwe), .file_wdata(fwd), .dir_file_we(dir_file_we),
    .dir_file_sel(dir_file_sel), .dir_file_wdata(dir_file_wdata), .dir_file_rdata(drd), .dir_port_a(dir_a),
    .dir_port_b(dir_b), .dir_port_c(dir_c), .w_reg(w_reg), .zero_flag(zf), .zero_we(zwe),
    .instr_done(instr_done));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Results are judged in the done cycle, when all pulses stand
  task automatic run(input logic [13:0] op, input logic [7:0] rd);
    int i;
    @(posedge clk_sys);
    file_rdata  <= rd;
    opcode      <= op;
    instr_start <= 1'b1;
    @(posedge clk_sys);
    instr_start <= 1'b0;
    for (i = 0; i < 8 && instr_done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK("done", 1'b1, instr_done)
    if (instr_done !== 1'b1) final_report();
  endtask : run
  task automatic t_xorl();
    run(14'h3AB5, 8'h00);
    `CHK("w", 8'hB5, w_reg)
    run(14'h3AAF, 8'h00);
    `CHK("w", 8'h1A, w_reg)
    `CHK("z", 1'b0, zf)
    run(14'h3A1A, 8'h00);
    `CHK("zwe", 1'b1, zwe)
    `CHK("z", 1'b1, zf)
    $display("literal xor done");
  endtask : t_xorl
  task automatic t_swap();
    run({6'h0E, 1'b0, 7'h21}, 8'hA5);
    `CHK("w", 8'h5A, w_reg)
    `CHK("zwe", 1'b0, zwe)
    run({6'h0E, 1'b1, 7'h21}, 8'h3C);
    `CHK("fwe", 1'b1, fwe)
    `CHK("fwd", 8'hC3, fwd)
    `CHK("addr", 7'h21, faddr)
    $display("swap done");
  endtask : t_swap
  task automatic t_xorf();
    run({6'h06, 1'b1, 7'h05}, 8'hAF);
    `CHK("fwd", 8'hF5, fwd)
    `CHK("w", 8'h5A, w_reg)
    `CHK("z", 1'b0, zf)
    run({6'h06, 1'b0, 7'h05}, 8'h5A);
    `CHK("fwe", 1'b0, fwe)
    `CHK("w", 8'h00, w_reg)
    `CHK("z", 1'b1, zf)
    $display("register xor done");
  endtask : t_xorf
  task automatic t_dir();
    run(14'h3A96, 8'h00);
    run({11'h00C, 3'h6}, 8'h00);
    `CHK("dirb", 8'h96, dir_b)
    `CHK("dira", 8'hFF, dir_a)
    `CHK("zwe", 1'b0, zwe)
    @(posedge clk_sys);
    dir_file_we    <= 1'b1;
    dir_file_sel   <= 2'd2;
    dir_file_wdata <= 8'h3C;
    @(posedge clk_sys);
    dir_file_we <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("dirc", 8'h3C, dir_c)
    `CHK("rd", 8'h3C, drd)
    $display("direction load done");
  endtask : t_dir
  task automatic t_refuse();
    int i;
    int dones;
    // Load selector 4 is not a direction register: nothing may move
    run({11'h00C, 3'h4}, 8'h00);
    `CHK("w", 8'h96, w_reg)
    `CHK("dira", 8'hFF, dir_a)
    `CHK("dirb", 8'h96, dir_b)
    `CHK("dirc", 8'h3C, dir_c)
    `CHK("zwe", 1'b0, zwe)
    `CHK("fwe", 1'b0, fwe)
    // Selector 3 has no direction register behind it
    @(posedge clk_sys);
    dir_file_we    <= 1'b1;
    dir_file_sel   <= 2'd3;
    dir_file_wdata <= 8'h00;
    @(posedge clk_sys);
    dir_file_we <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("rd3", 8'h00, drd)
    `CHK("dirc", 8'h3C, dir_c)
    // A start while busy is ignored and the latched opcode is used
    @(posedge clk_sys);
    opcode      <= 14'h3A0F;
    instr_start <= 1'b1;
    @(posedge clk_sys);
    instr_start <= 1'b0;
    @(posedge clk_sys);
    opcode      <= 14'h3AFF;
    instr_start <= 1'b1;
    @(posedge clk_sys);
    instr_start <= 1'b0;
    dones = 0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      if (instr_done === 1'b1) dones++;
    end
    `CHK("dones", 1, dones)
    `CHK("w", 8'h99, w_reg)
    `CHK("z", 1'b0, zf)
    $display("refused requests done");
  endtask : t_refuse
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK("w0", 8'h00, w_reg)
    `CHK("dir0", 8'hFF, dir_c)
    t_xorl();
    t_swap();
    t_xorf();
    t_dir();
    t_refuse();
    final_report();
  end
endmodule : sxteu_exec_tb_top
